// *** rtl/wdtrm_pkg.sv ***
package wdtrm_pkg;

  // counter geometry
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned PRE_W         = 8;

  // prescaler selection codes
  typedef enum logic [1:0] {
    WDTRM_DIV2   = 2'b00,
    WDTRM_DIV4   = 2'b01,
    WDTRM_DIV128 = 2'b10,
    WDTRM_DIV256 = 2'b11
  } wdtrm_div_t;

  // terminal counts of the prescaler (divide minus one)
  localparam logic [7:0] PRE_TC_DIV2    = 8'h01;
  localparam logic [7:0] PRE_TC_DIV4    = 8'h03;
  localparam logic [7:0] PRE_TC_DIV128  = 8'h7F;
  localparam logic [7:0] PRE_TC_DIV256  = 8'hFF;

  // register offsets
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_RELOAD    = 4'h1;
  localparam logic [3:0] ADDR_CMD       = 4'h2;
  localparam logic [3:0] ADDR_COUNT     = 4'h3;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;

  // control register fields
  localparam int unsigned CTRL_DIV_LSB  = 0;
  localparam int unsigned CTRL_ENH_BIT  = 2;

  // command register bits (write one to issue)
  localparam int unsigned CMD_SERVICE   = 0;
  localparam int unsigned CMD_DISABLE   = 1;
  localparam int unsigned CMD_ENABLE    = 2;
  localparam int unsigned CMD_END_INIT  = 3;

  // status register bits
  localparam int unsigned STAT_RUN      = 0;
  localparam int unsigned STAT_INITDONE = 1;
  localparam int unsigned STAT_WDTRST   = 2;

  // reset values
  localparam wdtrm_div_t  RST_DIV       = WDTRM_DIV2;
  localparam logic [7:0]  RST_RELOAD    = 8'h00;
  localparam logic        RST_ENH       = 1'b0;
  localparam logic [15:0] RST_COUNT     = 16'h0000;

  // length of the reset indication pulse after an overflow, in cycles
  localparam logic [7:0]  RST_PULSE_CYC = 8'h10;

endpackage

// *** rtl/wdtrm_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none

module wdtrm_prescaler (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // control
  input  wire logic                run,
  input  wire logic                clear,
  input  wire wdtrm_pkg::wdtrm_div_t div_sel,
  // tick out
  output logic                     tick
);
  import wdtrm_pkg::*;

  logic [PRE_W-1:0] pre_cnt;
  logic [PRE_W-1:0] term;

  // terminal count for the chosen divider
  always_comb begin
    case (div_sel)
      WDTRM_DIV2:   term = PRE_TC_DIV2;
      WDTRM_DIV4:   term = PRE_TC_DIV4;
      WDTRM_DIV128: term = PRE_TC_DIV128;
      WDTRM_DIV256: term = PRE_TC_DIV256;
      default:      term = PRE_TC_DIV2;
    endcase
  end

  // tick is one cycle when the prescaler wraps
  assign tick = clk_en & run & (pre_cnt >= term);

  // prescaler counter; clear restarts the phase on service
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 8'h00;
    end else if (clk_en) begin
      if (clear || !run || pre_cnt >= term) begin
        pre_cnt <= 8'h00;
      end else begin
        pre_cnt <= pre_cnt + 8'h01;
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/wdtrm_top.sv ***
// Behaviour
// [RULE_01] watchdog runs enabled after every reset
// [RULE_02] compatible mode: disable only before end-of-init
// [RULE_03] enhanced mode: disable/enable at any time
// [RULE_04] overflow: internal reset, reset output low
// [RULE_05] 16-bit counter, divider 2/4/128/256
// [RULE_06] programmable reload sets counter high byte
// [RULE_07] service loads high byte, clears low
// [RULE_08] software services before overflow
// [RULE_09] default interval 3.28 ms at 40 MHz
// [RULE_10] reset: divide-by-two, reload zero
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module wdtrm_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // reset outputs
  output logic             wdt_reset_req,
  output logic             reset_indication_output_n
);
  import wdtrm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // registers and decoded commands

  wdtrm_div_t  div_sel;
  logic [7:0]  reload_high_byte_value;
  logic        enh_mode;
  logic        run;
  logic        init_done;
  logic        wdt_caused;
  logic [15:0] wdt_count;
  logic [7:0]  pulse_cnt;
  logic        tick;
  logic        overflow;

  logic wr_ctrl;
  logic wr_reload;
  logic wr_cmd;
  logic service_cmd;
  logic watchdog_disable_instruction;
  logic watchdog_enable_instruction;
  logic end_of_init_instruction;

  // decode; inputs taken synchronous, clk_en gates all effects
  assign wr_ctrl     = clk_en & reg_wr & (reg_addr == ADDR_CTRL);
  assign wr_reload   = clk_en & reg_wr & (reg_addr == ADDR_RELOAD);
  assign wr_cmd      = clk_en & reg_wr & (reg_addr == ADDR_CMD);
  assign service_cmd = wr_cmd & reg_wdata[CMD_SERVICE];
  assign watchdog_disable_instruction = wr_cmd & reg_wdata[CMD_DISABLE];
  assign watchdog_enable_instruction  = wr_cmd & reg_wdata[CMD_ENABLE];
  assign end_of_init_instruction      = wr_cmd & reg_wdata[CMD_END_INIT];

  // overflow when the counter wraps on a tick
  assign overflow = tick & (wdt_count == 16'hFFFF);

  //////////////////////////////////////////////////////////////////////////
  // configuration registers

  // divider and mode; locked after end-of-init in either mode
  // [RULE_10] divide-by-two at reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_sel  <= RST_DIV;
      enh_mode <= RST_ENH;
    end else if (wr_ctrl && !init_done) begin
      div_sel  <= wdtrm_div_t'(reg_wdata[CTRL_DIV_LSB +: 2]);
      enh_mode <= reg_wdata[CTRL_ENH_BIT];
    end
  end

  // [RULE_06] reload value register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_high_byte_value <= RST_RELOAD;
    end else if (wr_reload) begin
      reload_high_byte_value <= reg_wdata[7:0];
    end
  end

  // end-of-init latch; only a reset reopens it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done <= 1'b0;
    end else if (end_of_init_instruction) begin
      init_done <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // run control

  // [RULE_01] running out of reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= 1'b1;
    end else if (clk_en) begin
      if (enh_mode) begin
        // [RULE_03] enhanced enable/disable; enable wins a tie for safety
        if (watchdog_enable_instruction) begin
          run <= 1'b1;
        end else if (watchdog_disable_instruction) begin
          run <= 1'b0;
        end
      end else begin
        // [RULE_02] compatible disable before end-of-init
        if (watchdog_disable_instruction && !init_done) begin
          run <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // prescaler and counter

  // [RULE_05] selectable divider tick
  wdtrm_prescaler u_pre (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .run     (run),
    .clear   (service_cmd),
    .div_sel (div_sel),
    .tick    (tick)
  );

  // [RULE_05] 16-bit count, service overrides tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // [RULE_09] count from zero gives full 65536 ticks
      wdt_count <= RST_COUNT;
    end else if (clk_en) begin
      if (service_cmd) begin
        // [RULE_07] reload high, clear low
        wdt_count <= {reload_high_byte_value, 8'h00};
      end else if (overflow) begin
        // restart from the reload value so a late service is still safe
        wdt_count <= {reload_high_byte_value, 8'h00};
      end else if (tick) begin
        wdt_count <= wdt_count + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reset generation

  // [RULE_04] stretched reset pulse after overflow
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt <= 8'h00;
    end else if (clk_en) begin
      if (overflow && !service_cmd) begin
        pulse_cnt <= RST_PULSE_CYC;
      end else if (pulse_cnt != 8'h00) begin
        pulse_cnt <= pulse_cnt - 8'h01;
      end
    end
  end

  // [RULE_04] outputs registered from the overflow and the pulse counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_reset_req             <= 1'b0;
      reset_indication_output_n <= 1'b1;
    end else if (clk_en) begin
      wdt_reset_req             <= (overflow && !service_cmd) || (pulse_cnt > 8'h01);
      reset_indication_output_n <= !((overflow && !service_cmd) || (pulse_cnt > 8'h01));
    end
  end

  // sticky cause flag; a set beats a clear write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_caused <= 1'b0;
    end else if (clk_en) begin
      if (overflow && !service_cmd) begin
        wdt_caused <= 1'b1;
      end else if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STAT_WDTRST]) begin
        wdt_caused <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_CTRL:   reg_rdata <= {13'h0000, enh_mode, div_sel};
          ADDR_RELOAD: reg_rdata <= {8'h00, reload_high_byte_value};
          ADDR_COUNT:  reg_rdata <= wdt_count;
          ADDR_STATUS: reg_rdata <= {13'h0000, wdt_caused, init_done, run};
          default:     reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// *** test/wdtrm_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdtrm_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // reset outputs
  input wire logic        wdt_reset_req,
  input wire logic        reset_indication_output_n
);
  import wdtrm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [9:0] gap;
  logic       svc;
  // service strobe; timing checks assume clk_en stays high
  assign svc = reg_wr && clk_en && reg_addr == ADDR_CMD && reg_wdata[CMD_SERVICE];
  // cycles since the last request, saturating
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) gap <= 10'h000;
    else gap <= wdt_reset_req ? 10'h000 : gap + {9'h000, gap != 10'h3FF};
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_inv; reset_indication_output_n == !wdt_reset_req; endproperty
  a_inv: assert property (p_inv) else $error("reset pins disagree");
  property p_pulse;
    $rose(wdt_reset_req) |-> wdt_reset_req[*8] ##1 wdt_reset_req[*8] ##1 !wdt_reset_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length");
  // a reload of FF at divide-by-two is the shortest interval
  property p_gap; $rose(wdt_reset_req) |-> gap >= 10'h1E0; endproperty
  a_gap: assert property (p_gap) else $error("overflow too early");
  property p_svc_lo; svc ##2 (reg_rd && reg_addr == ADDR_COUNT) |=> reg_rdata[7:0] <= 8'h01;
  endproperty
  a_svc_lo: assert property (p_svc_lo) else $error("low byte not cleared");
  property p_svc_quiet; svc |=> !$rose(wdt_reset_req); endproperty
  a_svc_quiet: assert property (p_svc_quiet) else $error("overflow after service");
  property p_first; $rose(rst_n) |-> !wdt_reset_req ##1 !wdt_reset_req; endproperty
  a_first: assert property (p_first) else $error("request after reset");
  property p_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_cmd_rd; reg_rd && reg_addr == ADDR_CMD |=> reg_rdata == 16'h0000; endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command reads nonzero");
endmodule
bind wdtrm_top wdtrm_checker u_chk (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .wdt_reset_req, .reset_indication_output_n);
`default_nettype wire

// *** test/test_watchdog_timer_reset_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timer_reset_monitor;
  import wdtrm_pkg::*;
  // stimulus and observed signals
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        clk_en    = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_rdata;
  logic        wdt_reset_req;
  logic        reset_indication_output_n;
  int          errors      = 0;
  int          check_count = 0;
  int          cyc         = 0;
  logic [15:0] v;
  logic [15:0] w;
  wdtrm_top dut (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .wdt_reset_req, .reset_indication_output_n);
  initial forever #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e, input string nm);
    rd(a, v);
    chk(nm, v, e);
  endtask
  // count advance between two reads taken m cycles apart
  task automatic delta(input int m, output logic [15:0] d);
    rd(ADDR_COUNT, v);
    repeat (m - 2) @(posedge sys_clk);
    rd(ADDR_COUNT, w);
    d = w - v;
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rc(ADDR_STATUS, 16'h0001, "status");
    rc(ADDR_CTRL, 16'h0000, "ctrl");
    rc(ADDR_RELOAD, 16'h0000, "reload");
    rc(4'hF, 16'h0000, "unmapped");
  endtask
  task automatic t_div;
    int n;
    for (int d = 0; d < 4; d++) begin
      n = (d < 2) ? 2 << d : 128 << (d - 2);
      wr(ADDR_CTRL, 16'(d));
      delta(4 * n, w);
      chk("ticks", w, 16'h0004);
    end
  endtask
  task automatic t_svc;
    wr(ADDR_RELOAD, 16'h12AB);
    rc(ADDR_RELOAD, 16'h00AB, "reload");
    wr(ADDR_CMD, 16'h0001);
    rd(ADDR_COUNT, v);
    chk("count", {v[15:1], 1'b0}, 16'hAB00);
  endtask
  // reload FF at divide-by-two overflows after 256 ticks
  task automatic t_ovf;
    int n;
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_RELOAD, 16'h00FF);
    wr(ADDR_CMD, 16'h0001);
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("interval", 16'(n >= 510 && n <= 516), 16'h0001);
    chk("reset_out", 16'(reset_indication_output_n), 16'h0000);
    repeat (20) @(posedge sys_clk);
    rc(ADDR_STATUS, 16'h0005, "status");
    wr(ADDR_STATUS, 16'h0004);
    rc(ADDR_STATUS, 16'h0001, "status");
  endtask
  task automatic t_compat;
    do_reset;
    wr(ADDR_CMD, 16'h0002);
    rc(ADDR_STATUS, 16'h0000, "status");
    wr(ADDR_CMD, 16'h0004);
    rc(ADDR_STATUS, 16'h0000, "status");
    do_reset;
    wr(ADDR_CMD, 16'h0008);
    wr(ADDR_CMD, 16'h0002);
    wr(ADDR_CTRL, 16'h0004);
    rc(ADDR_STATUS, 16'h0003, "status");
    rc(ADDR_CTRL, 16'h0000, "ctrl");
    rc(ADDR_CMD, 16'h0000, "cmd");
  endtask
  task automatic t_enh;
    do_reset;
    wr(ADDR_CTRL, 16'h0004);
    wr(ADDR_CMD, 16'h0008);
    wr(ADDR_CMD, 16'h0002);
    rc(ADDR_STATUS, 16'h0002, "status");
    delta(20, w);
    chk("stopped", w, 16'h0000);
    wr(ADDR_CMD, 16'h0004);
    delta(20, w);
    chk("running", w, 16'h000A);
    // clock enable low must freeze the count
    rd(ADDR_COUNT, v);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (20) @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(ADDR_COUNT, w);
    chk("frozen", 16'((w - v) < 16'h0003), 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset;
    t_reset;
    t_div;
    t_svc;
    t_ovf;
    t_compat;
    t_enh;
    tally_and_finish;
  end
  // hang guard, well above the few thousand cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish;
    end
  end
endmodule
`default_nettype wire
